// file: rtl/dglp_regs.sv
`timescale 1ns/1ns
module dglp_regs (
   // Clock, reset, clock enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [dglp_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [dglp_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [dglp_pkg::BE_W-1:0] avs_byteenable,
   output logic [dglp_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Converter and wideband filter samples
   input wire dglp_pkg::dglp_samp_vec_t converter_in,
   input wire dglp_pkg::dglp_samp_vec_t wideband_in,
   input wire logic wideband_path_active,
   // Channel outputs
   output dglp_pkg::dglp_samp_vec_t chan_out,
   output logic [2:0] latency_align_setting,
   output dglp_pkg::dglp_cfg_t cfg_out
);
   import dglp_pkg::*;

   // =====================================================
   // Bus handshake
   logic ack_r;
   logic ack_nxt;
   logic req;
   logic rd_first;
   logic wr_commit;
   logic [IDX_W-1:0] idx;

   assign req = avs_read | avs_write;
   // Unmapped indices still get the wait state
   assign idx = avs_address[IDX_LSB +: IDX_W];
   // One wait state, answer on the second cycle of a request
   assign avs_waitrequest = req & ~(ack_r & ce);
   assign rd_first = avs_read & ~ack_r;
   // Write lands on the edge that ends the answer cycle, one after the wait
   assign wr_commit = avs_write & ack_r & ce & avs_byteenable[0];

   // Ack lasts one cycle, so every request waits once
   always_comb begin
      ack_nxt = req & ~ack_r;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else if (ce) begin
         ack_r <= ack_nxt;
      end
   end

   // =====================================================
   // Configuration registers
   dglp_cfg_t cfg_r;
   dglp_cfg_t cfg_nxt;
   logic [BYTE_W-1:0] wbyte;

   // Only byte lane 0 carries register data
   assign wbyte = avs_writedata[BYTE_W-1:0];

   always_comb begin
      cfg_nxt = cfg_r;
      // Reserved bits of a written byte are dropped
      if (wr_commit) begin
         case (idx)
            IDX_GAIN_ONE: begin
               cfg_nxt.first_converter_gain_boost = wbyte[GAIN_BIT]; // [RULE_01]
            end
            IDX_GAIN_TWO: begin
               cfg_nxt.second_converter_gain_boost = wbyte[GAIN_BIT]; // [RULE_01]
            end
            IDX_LAT_ALIGN: begin
               cfg_nxt.latency_align_setting = wbyte[LAT_MSB:LAT_LSB]; // [RULE_04]
            end
            IDX_WB_GAIN: begin
               cfg_nxt.wideband_filter_gain_boost = wbyte[GAIN_BIT]; // [RULE_03]
            end
            IDX_PAT1_LO: begin
               cfg_nxt.custom_word_one[BYTE_W-1:0] = wbyte; // [RULE_06]
            end
            IDX_PAT1_HI: begin
               cfg_nxt.custom_word_one[SAMP_W-1:BYTE_W] = wbyte; // [RULE_06]
            end
            IDX_PAT2_LO: begin
               cfg_nxt.custom_word_two[BYTE_W-1:0] = wbyte; // [RULE_06]
            end
            IDX_PAT2_HI: begin
               cfg_nxt.custom_word_two[SAMP_W-1:BYTE_W] = wbyte; // [RULE_06]
            end
            IDX_PAT_SEL: begin // [RULE_09] [RULE_10]
               cfg_nxt.pattern_sel = wbyte[SEL_MSB:SEL_LSB];
            end
            default: begin
               cfg_nxt = cfg_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= CFG_RESET; // [RULE_08]
      end else if (ce) begin
         cfg_r <= cfg_nxt; // [RULE_11]
      end
   end

   // Live settings for the formatter and datapath
   assign cfg_out = cfg_r;
   assign latency_align_setting = cfg_r.latency_align_setting;

   // =====================================================
   // Read data
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [BYTE_W-1:0] rbyte;

   always_comb begin
      // Unmapped indices and reserved bits read zero
      rbyte = '0;
      case (idx)
         IDX_GAIN_ONE: begin
            rbyte[GAIN_BIT] = cfg_r.first_converter_gain_boost;
         end
         IDX_GAIN_TWO: begin
            rbyte[GAIN_BIT] = cfg_r.second_converter_gain_boost;
         end
         IDX_LAT_ALIGN: begin
            rbyte[LAT_MSB:LAT_LSB] = cfg_r.latency_align_setting; // [RULE_04]
         end
         IDX_WB_GAIN: begin
            rbyte[GAIN_BIT] = cfg_r.wideband_filter_gain_boost;
         end
         IDX_PAT1_LO: begin
            rbyte = cfg_r.custom_word_one[BYTE_W-1:0]; // [RULE_06]
         end
         IDX_PAT1_HI: begin
            rbyte = cfg_r.custom_word_one[SAMP_W-1:BYTE_W]; // [RULE_06]
         end
         IDX_PAT2_LO: begin
            rbyte = cfg_r.custom_word_two[BYTE_W-1:0]; // [RULE_06]
         end
         IDX_PAT2_HI: begin
            rbyte = cfg_r.custom_word_two[SAMP_W-1:BYTE_W]; // [RULE_06]
         end
         IDX_PAT_SEL: begin
            rbyte[SEL_MSB:SEL_LSB] = cfg_r.pattern_sel;
         end
         default: begin
            rbyte = '0;
         end
      endcase
      // Read byte is captured on the first request cycle
      rdata_nxt = rdata_r;
      if (rd_first) begin
         rdata_nxt = {{(DATA_W-BYTE_W){1'b0}}, rbyte};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (ce) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Read data holds until the next read starts
   assign avs_readdata = rdata_r;

   // =====================================================
   // Shared pattern sequencers
   logic [SAMP_W-1:0] ramp_r;
   logic [SAMP_W-1:0] ramp_nxt;
   logic phase_r;
   logic phase_nxt;
   logic sel_ramp;
   logic sel_alt;

   assign sel_ramp = (cfg_r.pattern_sel == PAT_RAMP);
   assign sel_alt = (cfg_r.pattern_sel == PAT_TOGGLE) |
                    (cfg_r.pattern_sel == PAT_CUST_ALT);

   always_comb begin
      ramp_nxt = '0;
      phase_nxt = 1'b0;
      // Ramp restarts from zero each time it is selected
      if (sel_ramp) begin
         ramp_nxt = ramp_r + RAMP_STEP; // [RULE_09]
      end
      // Phase restarts so alternation opens on the first word
      if (sel_alt) begin
         phase_nxt = ~phase_r; // [RULE_09] [RULE_10]
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ramp_r <= '0;
         phase_r <= 1'b0;
      end else if (ce) begin
         ramp_r <= ramp_nxt;
         phase_r <= phase_nxt;
      end
   end

   // =====================================================
   // Saturating doubler, a plain shift would wrap
   function automatic logic [SAMP_W-1:0] sat_double(
      input logic [SAMP_W-1:0] s
   );
      logic [SAMP_W-1:0] d;
      if (s[SAMP_W-1] != s[SAMP_W-2]) begin
         d = s[SAMP_W-1] ? SAT_NEG : SAT_POS;
      end else begin
         d = {s[SAMP_W-2:0], 1'b0};
      end
      return d;
   endfunction : sat_double

   // =====================================================
   // Per-channel gain and pattern mux
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
         logic [SAMP_W-1:0] src;
         logic boost;
         logic [SAMP_W-1:0] scaled;
         logic [SAMP_W-1:0] out_nxt;
         logic [SAMP_W-1:0] out_r;
         logic conv_boost;

         always_comb begin
            if (ch == 0) begin
               conv_boost = cfg_r.first_converter_gain_boost;
            end else begin
               conv_boost = cfg_r.second_converter_gain_boost;
            end
            // Wideband path ignores the converter gain bits
            if (wideband_path_active) begin
               src = wideband_in[ch];
               boost = cfg_r.wideband_filter_gain_boost; // [RULE_02] [RULE_03]
            end else begin
               src = converter_in[ch];
               boost = conv_boost; // [RULE_01]
            end
            if (boost) begin
               scaled = sat_double(src); // [RULE_01] [RULE_03]
            end else begin
               scaled = src;
            end
            case (cfg_r.pattern_sel)
               PAT_CONV: begin
                  out_nxt = scaled; // [RULE_09]
               end
               PAT_ZEROS: begin
                  out_nxt = WORD_ZERO; // [RULE_09]
               end
               PAT_ONES: begin
                  out_nxt = WORD_ONES; // [RULE_09]
               end
               PAT_TOGGLE: begin
                  out_nxt = phase_r ? WORD_TOG_B : WORD_TOG_A; // [RULE_09]
               end
               PAT_RAMP: begin
                  out_nxt = ramp_r; // [RULE_09]
               end
               PAT_CUST1: begin
                  out_nxt = cfg_r.custom_word_one; // [RULE_10]
               end
               PAT_CUST_ALT: begin
                  out_nxt = phase_r ? cfg_r.custom_word_two
                                    : cfg_r.custom_word_one; // [RULE_10]
               end
               PAT_DESKEW: begin
                  out_nxt = WORD_ONES; // [RULE_10]
               end
               // Unused codes fall back to converter data
               default: begin
                  out_nxt = scaled;
               end
            endcase
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               out_r <= '0;
            end else if (ce) begin
               out_r <= out_nxt; // [RULE_11]
            end
         end

         assign chan_out[ch] = out_r;
      end
   endgenerate

endmodule : dglp_regs

// file: rtl/dglp_pkg.sv
// Behaviour
// RULE_01 - Converter gain bit doubles that converter's output
// RULE_02 - Per-converter doubling skips wideband filter path
// RULE_03 - Wideband gain bit doubles wideband filter output
// RULE_04 - Latency alignment field sits in bits 6-4
// RULE_05 - Software writes alignment matching decimation factor
// RULE_06 - Two 16-bit custom patterns, four byte registers
// RULE_07 - Software writes zero to unused bits
// RULE_08 - Every field resets to zero
// RULE_09 - Select: data, zeros, ones, toggle, ramp
// RULE_10 - Select: custom one, alternating customs, deskew
// RULE_11 - Gain or alignment change applies next clock
package dglp_pkg;

   // =====================================================
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 6;

   // =====================================================
   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_GAIN_ONE = 6'h14;
   localparam logic [IDX_W-1:0] IDX_GAIN_TWO = 6'h16;
   localparam logic [IDX_W-1:0] IDX_LAT_ALIGN = 6'h1e;
   localparam logic [IDX_W-1:0] IDX_WB_GAIN = 6'h1f;
   localparam logic [IDX_W-1:0] IDX_PAT1_LO = 6'h33;
   localparam logic [IDX_W-1:0] IDX_PAT1_HI = 6'h34;
   localparam logic [IDX_W-1:0] IDX_PAT2_LO = 6'h35;
   localparam logic [IDX_W-1:0] IDX_PAT2_HI = 6'h36;
   localparam logic [IDX_W-1:0] IDX_PAT_SEL = 6'h37;

   // =====================================================
   // Field positions
   localparam int GAIN_BIT = 0;
   localparam int LAT_LSB = 4;
   localparam int LAT_MSB = 6;
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 3;
   localparam int BYTE_W = 8;

   // =====================================================
   // Reset values
   localparam logic RST_GAIN = 1'h0;
   localparam logic [2:0] RST_LAT = 3'h0;
   localparam logic [15:0] RST_PAT = 16'h0000;
   localparam logic [3:0] RST_SEL = 4'h0;

   // Alignment settings that software writes (field value)
   localparam logic [2:0] LAT_DIV_24_32 = 3'h1;
   localparam logic [2:0] LAT_DIV_16_20 = 3'h2;
   localparam logic [2:0] LAT_DIV_6_12 = 3'h4;
   localparam logic [2:0] LAT_DIV_4_10 = 3'h5;

   // =====================================================
   // Datapath
   localparam int SAMP_W = 16;
   localparam int NUM_CH = 2;
   localparam logic [SAMP_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [SAMP_W-1:0] WORD_ONES = 16'hffff;
   localparam logic [SAMP_W-1:0] WORD_TOG_A = 16'haaaa;
   localparam logic [SAMP_W-1:0] WORD_TOG_B = 16'h5555;
   localparam logic [SAMP_W-1:0] SAT_POS = 16'h7fff;
   localparam logic [SAMP_W-1:0] SAT_NEG = 16'h8000;
   localparam logic [SAMP_W-1:0] RAMP_STEP = 16'h0001;

   // Pattern select codes
   localparam logic [3:0] PAT_CONV = 4'h0;
   localparam logic [3:0] PAT_ZEROS = 4'h1;
   localparam logic [3:0] PAT_ONES = 4'h2;
   localparam logic [3:0] PAT_TOGGLE = 4'h3;
   localparam logic [3:0] PAT_RAMP = 4'h4;
   localparam logic [3:0] PAT_CUST1 = 4'h6;
   localparam logic [3:0] PAT_CUST_ALT = 4'h7;
   localparam logic [3:0] PAT_DESKEW = 4'h8;

   typedef logic [NUM_CH-1:0][SAMP_W-1:0] dglp_samp_vec_t;

   typedef struct packed {
      logic first_converter_gain_boost;
      logic second_converter_gain_boost;
      logic wideband_filter_gain_boost;
      logic [2:0] latency_align_setting;
      logic [SAMP_W-1:0] custom_word_one;
      logic [SAMP_W-1:0] custom_word_two;
      logic [3:0] pattern_sel;
   } dglp_cfg_t;

   localparam dglp_cfg_t CFG_RESET = '{
      first_converter_gain_boost: RST_GAIN,
      second_converter_gain_boost: RST_GAIN,
      wideband_filter_gain_boost: RST_GAIN,
      latency_align_setting: RST_LAT,
      custom_word_one: RST_PAT,
      custom_word_two: RST_PAT,
      pattern_sel: RST_SEL
   };

endpackage : dglp_pkg

// file: tb/dglp_checker.sv
`timescale 1ns/1ns
// ====================
// Port checker
module dglp_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input wire logic [dglp_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [dglp_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [dglp_pkg::BE_W-1:0] avs_byteenable,
   input wire logic avs_waitrequest,
   // Datapath
   input wire dglp_pkg::dglp_samp_vec_t converter_in,
   input wire dglp_pkg::dglp_samp_vec_t wideband_in,
   input wire logic wideband_path_active,
   input wire dglp_pkg::dglp_samp_vec_t chan_out,
   input wire logic [2:0] latency_align_setting,
   input wire dglp_pkg::dglp_cfg_t cfg_out
);
   import dglp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr(logic [5:0] i);
      avs_write && !avs_waitrequest && avs_byteenable[0] &&
      avs_address[7:2] == i;
   endsequence
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   property p_wait;
      s_req |=> !avs_waitrequest || !(avs_read || avs_write);
   endproperty
   a_wait: assert property (p_wait) else $error("no answer");
   property p_first;
      $rose(avs_write) |-> avs_waitrequest;
   endproperty
   a_first: assert property (p_first) else $error("no wait");
   property p_lat;
      s_wr(IDX_LAT_ALIGN) |=>
         latency_align_setting == $past(avs_writedata[6:4]);
   endproperty
   a_lat: assert property (p_lat) else $error("align");
   property p_gain;
      s_wr(IDX_GAIN_TWO) |=>
         cfg_out.second_converter_gain_boost == $past(avs_writedata[0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain");
   property p_pat;
      s_wr(IDX_PAT2_HI) |=>
         cfg_out.custom_word_two[15:8] == $past(avs_writedata[7:0]);
   endproperty
   a_pat: assert property (p_pat) else $error("pattern");
   property p_ones;
      cfg_out.pattern_sel == PAT_ONES |=> chan_out == {2{WORD_ONES}};
   endproperty
   a_ones: assert property (p_ones) else $error("ones");
   property p_pass;
      cfg_out.pattern_sel == PAT_CONV && wideband_path_active &&
      !cfg_out.wideband_filter_gain_boost |=> chan_out == $past(wideband_in);
   endproperty
   a_pass: assert property (p_pass) else $error("wideband");
   property p_dbl;
      cfg_out.pattern_sel == PAT_CONV && !wideband_path_active &&
      cfg_out.first_converter_gain_boost &&
      converter_in[0][15] == converter_in[0][14] |=>
         chan_out[0] == {$past(converter_in[0][14:0]), 1'b0};
   endproperty
   a_dbl: assert property (p_dbl) else $error("doubling");
endmodule : dglp_checker

bind dglp_regs dglp_checker u_chk (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
   .converter_in(converter_in), .wideband_in(wideband_in),
   .wideband_path_active(wideband_path_active), .chan_out(chan_out),
   .latency_align_setting(latency_align_setting), .cfg_out(cfg_out));

// file: tb/tb_ddc_gain_latency_pattern_regs.sv
`timescale 1ns/1ns
module tb_ddc_gain_latency_pattern_regs;
   import dglp_pkg::*;
   logic clk, rst, ce, avs_read, avs_write, wideband_path_active, wreq;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, rdata, q;
   logic [2:0] lat;
   dglp_samp_vec_t converter_in, wideband_in, chan_out;
   dglp_cfg_t cfg;
   int n_mismatch = 0;
   int checks = 0;
   logic [7:0] ad [9] = '{8'h50, 8'h58, 8'h78, 8'h7c, 8'hcc, 8'hd0,
      8'hd4, 8'hd8, 8'hdc};
   logic [7:0] vl [9] = '{8'h01, 8'h01, 8'h50, 8'h01, 8'h5a, 8'h3c,
      8'ha5, 8'hc3, 8'h07};
   logic [3:0] cd [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
   logic [15:0] e1 [7] = '{16'h0, 16'hffff, 16'haaaa, 16'h0, 16'h3c5a,
      16'h3c5a, 16'hffff};
   logic [15:0] e2 [7] = '{16'h0, 16'hffff, 16'h5555, 16'h1, 16'h3c5a,
      16'hc3a5, 16'hffff};
   dglp_regs dut (.clk(clk), .rst(rst), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h1), .avs_readdata(rdata),
      .avs_waitrequest(wreq), .converter_in(converter_in),
      .wideband_in(wideband_in),
      .wideband_path_active(wideband_path_active), .chan_out(chan_out),
      .latency_align_setting(lat), .cfg_out(cfg));
   // ====================
   // Helpers
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      // Hold the request until waitrequest is sampled low
      @(posedge clk);
      while (wreq !== 1'b0) begin
         @(posedge clk);
      end
      q = rdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task results;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results
   // ====================
   // Scenarios
   task t_rst;
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, ad[i], 8'h0);
         chk(q, 32'h0);
      end
      chk(chan_out, 32'h0);
      chk(32'(lat), 32'h0);
      chk(cfg[31:0], 32'h0);
      chk(32'(cfg[41:32]), 32'h0);
      $display("t_rst done");
   endtask : t_rst
   task t_gain;
      @(posedge clk);
      converter_in <= 32'h5000_1234;
      wideband_in <= 32'h0111_f000;
      bus(1'b1, 8'h50, 8'h01);
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h5000_2468);
      bus(1'b1, 8'h58, 8'h01);
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h7fff_2468);
      @(posedge clk);
      wideband_path_active <= 1'b1;
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h0111_f000);
      bus(1'b1, 8'h7c, 8'h01);
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h0222_e000);
      @(posedge clk);
      wideband_path_active <= 1'b0;
      bus(1'b1, 8'h50, 8'h00);
      bus(1'b1, 8'h58, 8'h00);
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h5000_1234);
      $display("t_gain done");
   endtask : t_gain
   task t_regs;
      for (int i = 0; i < 9; i++) begin
         bus(1'b1, ad[i], vl[i]);
         bus(1'b0, ad[i], 8'h0);
         chk(q, {24'h0, vl[i]});
      end
      bus(1'b1, 8'h54, 8'hff);
      bus(1'b0, 8'h54, 8'h0);
      chk(q, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task t_pat;
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 8'hdc, {4'h0, cd[i]});
         repeat (2) @(negedge clk);
         chk(chan_out, {2{e1[i]}});
         @(negedge clk);
         chk(chan_out, {2{e2[i]}});
      end
      $display("t_pat done");
   endtask : t_pat
   task t_lat;
      for (int i = 1; i < 6; i++) begin
         if (i != 3) begin
            bus(1'b1, 8'h78, 8'(i * 16));
            @(negedge clk);
            chk(32'(lat), 32'(i));
            bus(1'b0, 8'h78, 8'h0);
            chk(q, 32'(i * 16));
         end
      end
      $display("t_lat done");
   endtask : t_lat
   task t_ce;
      bus(1'b1, 8'hdc, 8'h04);
      repeat (4) @(posedge clk);
      ce <= 1'b0;
      repeat (5) @(negedge clk);
      chk(chan_out, 32'h0003_0003);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(negedge clk);
      chk(chan_out, 32'h0004_0004);
      $display("t_ce done");
   endtask : t_ce
   // ====================
   // Clock, sequence, watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h0;
      avs_writedata = 32'h0;
      converter_in = '0;
      wideband_in = '0;
      wideband_path_active = 1'b0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_rst;
      t_gain;
      t_regs;
      t_pat;
      t_lat;
      t_ce;
      results;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      results;
   end
endmodule : tb_ddc_gain_latency_pattern_regs
